// ---- hdl/rmf_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmf_framer
    import rmf_pkg::*;
#(
    parameter int unsigned CONN_CYC = CONN_TMO_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic [15:0] rx_port_in,
    input wire logic tx_valid_in,
    input wire logic sock_open_in,
    input wire logic [31:0] gap_cycles_in,
    input wire logic [15:0] set_value_in,
    input wire logic [15:0] set_limit_in,
    input wire logic set_check_in,
    output logic msg_done_out,
    output logic [1:0] msg_kind_out,
    output logic msg_query_out,
    output logic comm_err_out,
    output logic reject_out,
    output logic sock_close_out,
    output logic busy_out
);
    rmf_tmr_if #(.W(32)) gap_t ();
    rmf_tmr_if #(.W(32)) conn_t ();

    rmf_idle_timer #(.W(32)) u_gap (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .t(gap_t));
    rmf_idle_timer #(.W(32)) u_conn (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .t(conn_t));

    rmf_state_t st_q, st_d;
    rmf_kind_t kind_q, kind_d;
    logic [2:0] hdr_q, hdr_d;
    logic last_q, last_d;
    logic prev_cr_q, prev_cr_d;
    logic done_q, done_d;
    logic err_q, err_d;
    logic rej_q, rej_d;
    logic close_q, close_d;
    logic query_q, query_d;
    logic busy_q, busy_d;
    logic [31:0] lat_q, lat_d;
    logic framed;

    assign framed = (rx_port_in == FRAMED_PORT);

    // Timer controls: gap runs during a message, connection while socket is open.
    assign gap_t.restart = rx_valid_in;
    assign gap_t.run = (st_q != RMF_IDLE);
    // A zero setting picks the default gap; a long one is capped so that every message
    // is handed on inside the reply budget.
    assign gap_t.limit = (gap_cycles_in == 32'h0) ? GAP_RST :
        (gap_cycles_in >= REPLY_USB_CYC) ? 32'(REPLY_USB_CYC - 1) : gap_cycles_in;
    assign conn_t.restart = rx_valid_in || tx_valid_in;
    assign conn_t.run = sock_open_in;
    assign conn_t.limit = 32'(CONN_CYC);

    // Message delimiting and dispatch.
    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        hdr_d = hdr_q;
        last_d = last_q;
        prev_cr_d = prev_cr_q;
        done_d = 1'b0;
        err_d = 1'b0;
        rej_d = 1'b0;
        close_d = conn_t.expired;
        case (st_q)
            RMF_IDLE: begin
                if (rx_valid_in) begin
                    last_d = (rx_byte_in == CHAR_QUERY);
                    prev_cr_d = 1'b0;
                    if (framed) begin
                        kind_d = RMF_KIND_FRAMED;
                        hdr_d = 3'h1;
                        st_d = RMF_HDR;
                    end else begin
                        kind_d = rmf_classify(rx_byte_in);
                        st_d = RMF_BODY;
                    end
                end
            end
            RMF_HDR: begin
                if (rx_valid_in) begin
                    hdr_d = hdr_q + 3'h1;
                    if (32'(hdr_q) + 32'h1 >= MBAP_LEN) begin
                        st_d = RMF_BODY;
                    end
                end else if (gap_t.expired) begin
                    done_d = 1'b1;
                    err_d = 1'b1;
                    st_d = RMF_IDLE;
                end
            end
            RMF_BODY: begin
                if (rx_valid_in) begin
                    if (kind_q == RMF_KIND_TEXT && (rx_byte_in == CHAR_LF || rx_byte_in == CHAR_CR)) begin
                        prev_cr_d = (rx_byte_in == CHAR_CR);
                        done_d = (rx_byte_in == CHAR_LF) || !prev_cr_q;
                        st_d = RMF_TERM;
                    end else begin
                        last_d = (rx_byte_in == CHAR_QUERY);
                    end
                end else if (gap_t.expired) begin
                    done_d = 1'b1;
                    err_d = (kind_q == RMF_KIND_ERROR) && !framed;
                    st_d = RMF_IDLE;
                end
            end
            RMF_TERM: begin
                // Absorb a trailing LF after CR, without a second completion.
                if (rx_valid_in && rx_byte_in == CHAR_LF && prev_cr_q) begin
                    prev_cr_d = 1'b0;
                end else if (rx_valid_in) begin
                    last_d = (rx_byte_in == CHAR_QUERY);
                    prev_cr_d = 1'b0;
                    kind_d = rmf_classify(rx_byte_in);
                    st_d = RMF_BODY;
                end
                if (!rx_valid_in || gap_t.expired) begin
                    st_d = RMF_IDLE;
                end
            end
            default: st_d = RMF_IDLE;
        endcase
        if (set_check_in && set_value_in > set_limit_in) begin
            rej_d = 1'b1;
        end
        if (rej_d && kind_q != RMF_KIND_TEXT) begin
            err_d = 1'b1;
        end
        // Query and busy levels are registered so that the outputs come from flip-flops.
        query_d = last_d && (kind_d == RMF_KIND_TEXT);
        busy_d = (st_d != RMF_IDLE);
    end

    // Registered state and outputs.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= RMF_IDLE;
            kind_q <= RMF_KIND_MODBUS;
            hdr_q <= 3'h0;
            last_q <= 1'b0;
            prev_cr_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rej_q <= 1'b0;
            close_q <= 1'b0;
            query_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            hdr_q <= hdr_d;
            last_q <= last_d;
            prev_cr_q <= prev_cr_d;
            done_q <= done_d;
            err_q <= err_d;
            rej_q <= rej_d;
            close_q <= close_d;
            query_q <= query_d;
            busy_q <= busy_d;
        end
    end

    // Cycles since the last byte of the message in progress; bounds the hand-over time.
    always_comb begin
        lat_d = 32'h0;
        if (!rx_valid_in && st_q != RMF_IDLE) begin
            lat_d = lat_q + 32'h1;
        end
    end

    // Hand-over latency register.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lat_q <= 32'h0;
        end else begin
            lat_q <= lat_d;
        end
    end

    assign msg_done_out = done_q;
    assign msg_kind_out = kind_q;
    assign msg_query_out = query_q;
    assign comm_err_out = err_q;
    assign reject_out = rej_q;
    assign sock_close_out = close_q;
    assign busy_out = busy_q;

    property p_gap;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_BODY && gap_t.expired && !rx_valid_in) |=> msg_done_out;
    endproperty
    gap_done_a: assert property (p_gap) else $error("gap expiry gave no completion");
    idle_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (rx_valid_in && st_q == RMF_BODY && kind_q != RMF_KIND_TEXT) |=> !msg_done_out)
        else $error("completion without gap");
    term_done_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_BODY && kind_q == RMF_KIND_TEXT && rx_valid_in && rx_byte_in == CHAR_LF) |=> msg_done_out)
        else $error("terminator ignored");
    first_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_IDLE && rx_valid_in && !framed && rx_byte_in == 8'h00) |=> msg_kind_out == RMF_KIND_MODBUS)
        else $error("zero byte not ModBus");
    err_range_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_IDLE && rx_valid_in && !framed && rx_byte_in >= 8'h01 && rx_byte_in <= 8'h29)
        |=> msg_kind_out == RMF_KIND_ERROR) else $error("bad first byte accepted");
    framed_port_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_IDLE && rx_valid_in && framed) |=> msg_kind_out == RMF_KIND_FRAMED)
        else $error("port not framed");
    short_hdr_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_q == RMF_HDR && !rx_valid_in && gap_t.expired) |=> comm_err_out)
        else $error("short header accepted");
    limit_rej_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (set_check_in && set_value_in > set_limit_in) |=> reject_out)
        else $error("limit not enforced");
    conn_close_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        conn_t.expired |=> sock_close_out) else $error("idle socket kept");
    reply_budget_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        lat_q <= REPLY_USB_CYC) else $error("message held past reply budget");
    text_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (kind_q == RMF_KIND_TEXT) |=> !comm_err_out) else $error("error sent unasked in text mode");
    cv_text: cover property (@(posedge mclk_in) msg_done_out && msg_kind_out == RMF_KIND_TEXT);
    cv_mb: cover property (@(posedge mclk_in) msg_done_out && msg_kind_out == RMF_KIND_MODBUS);
    cv_framed: cover property (@(posedge mclk_in) msg_done_out && msg_kind_out == RMF_KIND_FRAMED);
    cv_close: cover property (@(posedge mclk_in) sock_close_out);
endmodule : rmf_framer
`default_nettype wire

// ---- hdl/rmf_pkg.sv ----
package rmf_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam logic [7:0] MODBUS_ADDR = 8'h00;
    localparam logic [7:0] TEXT_FIRST_MIN = 8'h2a;
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_QUERY = 8'h3f;
    localparam logic [15:0] FRAMED_PORT = 16'h01f6;
    localparam int unsigned MBAP_LEN = 6;
    localparam int unsigned REPLY_USB_MS = 5;
    localparam int unsigned REPLY_ETH_MS = 10;
    localparam int unsigned REPLY_USB_CYC = REPLY_USB_MS * 1000 * CLK_MHZ;
    localparam int unsigned REPLY_ETH_CYC = REPLY_ETH_MS * 1000 * CLK_MHZ;
    localparam int unsigned CONN_TMO_S = 5;
    localparam int unsigned CONN_TMO_CYC = CONN_TMO_S * 1000 * 1000 * CLK_MHZ;
    localparam logic [31:0] GAP_RST = 32'h0003_d090;
    localparam logic [15:0] SET_MAX_RST = 16'hcccc;

    typedef enum logic [1:0] {
        RMF_KIND_MODBUS,
        RMF_KIND_TEXT,
        RMF_KIND_FRAMED,
        RMF_KIND_ERROR
    } rmf_kind_t;

    typedef enum {
        RMF_IDLE,
        RMF_HDR,
        RMF_BODY,
        RMF_TERM
    } rmf_state_t;

    // Dispatch class chosen by the leading byte of an unframed message.
    function automatic rmf_kind_t rmf_classify(input logic [7:0] b);
        if (b == MODBUS_ADDR) begin
            return RMF_KIND_MODBUS;
        end else if (b < TEXT_FIRST_MIN) begin
            return RMF_KIND_ERROR;
        end
        return RMF_KIND_TEXT;
    endfunction : rmf_classify
endpackage : rmf_pkg

// ---- hdl/rmf_tmr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Restart and expiry of one idle timer.
interface rmf_tmr_if #(parameter int W = 32);
    logic restart;
    logic run;
    logic [W-1:0] limit;
    logic expired;
    modport owner (output restart, output run, output limit, input expired);
    modport timer (input restart, input run, input limit, output expired);
endinterface : rmf_tmr_if
`default_nettype wire

// ---- hdl/rmf_idle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmf_idle_timer #(
    parameter int W = 32
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    rmf_tmr_if.timer t
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic exp_q;
    logic exp_d;

    // Counts idle cycles; a restart clears it, expiry is a one-cycle pulse.
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (t.restart || !t.run) begin
            cnt_d = '0;
        end else if (cnt_q + W'(1) >= t.limit) begin
            exp_d = 1'b1;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    // Timer state.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign t.expired = exp_q;
endmodule : rmf_idle_timer
`default_nettype wire

// ---- dv/rmf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: sends whole messages and reply-read pulses.
module rmf_host_model (
    input wire logic mclk_in,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic [15:0] rx_port_out,
    output logic tx_valid_out
);
    // Idle host drives nothing valid.
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out = 8'h55;
        rx_port_out = 16'h0000;
        tx_valid_out = 1'b0;
    end
    // Bytes go back to back with valid held; the freed data line shows the inverse of the last byte.
    task automatic send_msg(input logic [7:0] m[$], input logic [15:0] port);
        rx_port_out = port;
        foreach (m[i]) begin
            rx_byte_out = m[i];
            rx_valid_out = 1'b1;
            @(posedge mclk_in);
            #1;
        end
        rx_valid_out = 1'b0;
        rx_byte_out = ~m[m.size()-1];
    endtask : send_msg
    // One read of the answer after a message, which is also link traffic.
    task automatic read_reply();
        tx_valid_out = 1'b1;
        @(posedge mclk_in);
        #1;
        tx_valid_out = 1'b0;
        repeat (4) @(posedge mclk_in);
        #1;
    endtask : read_reply
endmodule : rmf_host_model
`default_nettype wire

// ---- dv/remote_message_framer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_message_framer_tb_top;
    import rmf_pkg::*;
    localparam int GAP = 16;
    localparam int CONN = 1000;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sock_open = 1'b0;
    logic [31:0] gap = 32'h0000_0010;
    logic [15:0] set_val = 16'h0000;
    logic [15:0] set_lim = SET_MAX_RST;
    logic set_chk = 1'b0;
    logic rxv, txv, done, qry, err, rej, cls, busy;
    logic [7:0] rxb;
    logic [15:0] rxp;
    logic [1:0] kind;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [15:0] txt_port = 16'h13a1;
    int done_tally = 0;
    // Completion pulses, counted mid-cycle where the output has settled.
    always @(negedge mclk_in) begin
        done_tally += (done === 1'b1);
    end
    // Clock at 250 MHz.
    always #2 mclk_in = ~mclk_in;
    rmf_host_model host_u (.mclk_in(mclk_in), .rx_valid_out(rxv), .rx_byte_out(rxb), .rx_port_out(rxp),
        .tx_valid_out(txv));
    rmf_framer #(.CONN_CYC(CONN)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rx_valid_in(rxv),
        .rx_byte_in(rxb), .rx_port_in(rxp), .tx_valid_in(txv), .sock_open_in(sock_open),
        .gap_cycles_in(gap), .set_value_in(set_val), .set_limit_in(set_lim), .set_check_in(set_chk),
        .msg_done_out(done), .msg_kind_out(kind), .msg_query_out(qry), .comm_err_out(err),
        .reject_out(rej), .sock_close_out(cls), .busy_out(busy));
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    // Counts cycles to the completion pulse, looking first at the moment of the call, and keeps the error flag.
    task automatic wait_done(output int n, output logic e);
        n = 0;
        e = 1'b0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        e = err;
        chk(done === 1'b1, "no completion seen");
    endtask : wait_done
    task automatic t_term();
        int n;
        logic e;
        int t0;
        host_u.send_msg('{8'h2a, 8'h52, 8'h0a}, txt_port);
        wait_done(n, e);
        chk(n <= 2, "terminator did not end message at once");
        chk(kind === RMF_KIND_TEXT && e === 1'b0, "text kind wrong");
        host_u.read_reply();
        t0 = done_tally;
        host_u.send_msg('{8'h2a, 8'h52, 8'h0d, 8'h0a}, txt_port);
        repeat (4) @(posedge mclk_in);
        #1;
        chk(done_tally - t0 == 1 && busy === 1'b0, "CR LF pair not one completion");
        $display("test term done");
    endtask : t_term
    task automatic t_gap();
        int n;
        logic e;
        host_u.send_msg('{8'h00, 8'h03}, txt_port);
        chk(busy === 1'b1, "busy missing while gap runs");
        wait_done(n, e);
        chk(n >= GAP + 1 && n <= GAP + 2, "gap completion time wrong");
        chk(kind === RMF_KIND_MODBUS && e === 1'b0 && busy === 1'b0, "modbus kind wrong");
        host_u.read_reply();
        host_u.send_msg('{8'h2a, 8'h3f}, txt_port);
        wait_done(n, e);
        chk(qry === 1'b1 && kind === RMF_KIND_TEXT, "query not flagged");
        host_u.read_reply();
        gap = 32'h0000_0014;
        host_u.send_msg('{8'h00, 8'h03}, txt_port);
        wait_done(n, e);
        chk(n >= GAP + 5 && n <= GAP + 6, "raised gap not applied");
        gap = 32'h0000_0010;
        $display("test gap done");
    endtask : t_gap
    task automatic t_first();
        logic [7:0] fb[4] = '{8'h01, 8'h29, 8'h2a, 8'hff};
        int n;
        logic e;
        logic bad;
        foreach (fb[i]) begin
            bad = (fb[i] <= 8'h29);
            host_u.send_msg('{fb[i]}, txt_port);
            wait_done(n, e);
            chk(e === bad, "first byte error flag wrong");
            chk(kind === (bad ? RMF_KIND_ERROR : RMF_KIND_TEXT), "first byte kind wrong");
            host_u.read_reply();
        end
        $display("test first done");
    endtask : t_first
    task automatic t_framed();
        int n;
        logic e;
        host_u.send_msg('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h03}, FRAMED_PORT);
        wait_done(n, e);
        chk(kind === RMF_KIND_FRAMED && e === 1'b0, "framed message refused");
        host_u.read_reply();
        host_u.send_msg('{8'h2a, 8'h52, 8'h3f}, FRAMED_PORT);
        wait_done(n, e);
        chk(e === 1'b1, "short framed message accepted");
        $display("test framed done");
    endtask : t_framed
    // Limit checks after a text message and after a ModBus message; only the latter reports an error.
    task automatic t_limit();
        int hits;
        int errs;
        int n;
        logic e;
        for (int k = 0; k < 4; k++) begin
            if (k < 2) begin
                host_u.send_msg('{8'h2a, 8'h0a}, txt_port);
            end else begin
                host_u.send_msg('{8'h00}, txt_port);
            end
            wait_done(n, e);
            set_val = set_lim + 16'(k % 2);
            set_chk = 1'b1;
            hits = 0;
            errs = 0;
            repeat (3) begin
                @(posedge mclk_in);
                #1;
                set_chk = 1'b0;
                hits += (rej === 1'b1);
                errs += (err === 1'b1);
            end
            chk(hits == k % 2, "limit check wrong");
            chk(errs == (k == 3 ? 1 : 0), "error report wrong for mode");
        end
        $display("test limit done");
    endtask : t_limit
    task automatic t_conn();
        int n = 0;
        int early = 0;
        sock_open = 1'b1;
        repeat (CONN / 2) begin
            @(posedge mclk_in);
            #1;
            early += (cls === 1'b1);
        end
        host_u.read_reply();
        n = 4;
        while (cls !== 1'b1 && n < CONN + 20) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk(early == 0, "socket closed too early");
        chk(n >= CONN - 5 && n <= CONN + 5, "socket close time wrong");
        sock_open = 1'b0;
        $display("test conn done");
    endtask : t_conn
    task automatic end_of_test();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after three reset cycles.
    initial begin
        repeat (3) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        t_term();
        t_gap();
        t_first();
        t_framed();
        t_limit();
        t_conn();
        end_of_test();
    end
    // Watchdog well past the expected run time.
    initial begin
        #80000;
        error_cnt++;
        end_of_test();
    end
endmodule : remote_message_framer_tb_top
`default_nettype wire
